// ===== hw/bfp_top.sv
// Our own choices: the address map and register access over APB.
`include "bfp_defines.svh"

// Notes on behaviour
// - Word addresses to 1DFF are application, 1E00 to 1FFF are boot.
// - Pages hold 128 bytes; the boot part is eight pages.
// - Flash stores may target anywhere but run only when fetched from boot.
// - Two independent two-bit lock settings: application part and boot part.
// - Lock bits programmed by software or programmer; only chip erase clears; here RESET_I also returns them to 1.
// - Lock and fuse bits read 1 unprogrammed, 0 programmed.
// - Application lock 11 places no restriction on application accesses.
// - Application write lock programmed refuses stores into application.
// - Application read lock programmed refuses boot-code loads of application.
// - Boot lock 11 places no restriction on boot accesses.
// - Boot write lock programmed refuses stores into boot part.
// - Boot read lock programmed refuses application-code loads of boot.
// - Reset vector 0000 with fuse unprogrammed, 1E00 when programmed.
// - Running code cannot alter fuses; only the programming port can.
// - General lock bit one programmed blocks fuse change until erase; here RESET_I also returns it and the fuse to 1.
// - Lock-set store programs locks whose data bits 5 to 2 are zero.
module bfp_top
    import bfp_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    // Core access port.
    input wire logic ACC_VALID_I,
    input wire bfp_pkg::bfp_acc_e ACC_KIND_I,
    input wire bfp_pkg::bfp_waddr_t ACC_ADDR_I,
    input wire bfp_pkg::bfp_waddr_t FETCH_PC_I,
    input wire logic [7:0] ACC_DATA_I,
    // Flash array side.
    output logic FLASH_WR_O,
    output logic FLASH_RD_O,
    output bfp_pkg::bfp_waddr_t FLASH_ADDR_O,
    input wire logic [15:0] FLASH_RDATA_I,
    // Answer to the core.
    output logic ACC_DONE_O,
    output logic ACC_REFUSED_O,
    output logic [15:0] ACC_RDATA_O,
    output bfp_pkg::bfp_waddr_t RESET_VECTOR_O,
    // APB slave.
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O
);
    import bfp_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Partition decode is used for both target and fetch address.
    function automatic logic in_boot(input bfp_waddr_t a);
        in_boot = (a >= `BFP_BOOT_FIRST) && (a <= `BFP_BOOT_LAST);
    endfunction

    // Page number of a word address, 64 words to a page.
    function automatic logic [6:0] page_of(input bfp_waddr_t a);
        page_of = a[12:6];
    endfunction

    logic [3:0] lock;
    logic fuse;
    logic gl1;
    logic [1:0] app_lock;
    logic [1:0] boot_lock;
    logic app_write_lock_bit;
    logic app_read_lock_bit;
    logic boot_write_lock_bit;
    logic boot_read_lock_bit;
    logic tgt_boot;
    logic pc_boot;
    logic allow;
    logic is_store;
    logic is_load;
    logic is_lockset;
    logic rd_pend;
    logic apb_wr;
    logic apb_rd;
    logic prog_erase;
    logic prog_fuse_wr;
    logic prog_gl1;
    logic boot_page_ok;

    // ------------------------------------------------------------------
    // Lock decode
    // ------------------------------------------------------------------
    // Bits are active low: zero means programmed, i.e. restriction on.
    assign app_lock = lock[1:0];
    assign boot_lock = lock[3:2];
    assign app_write_lock_bit = app_lock[0];
    assign app_read_lock_bit = app_lock[1];
    assign boot_write_lock_bit = boot_lock[0];
    assign boot_read_lock_bit = boot_lock[1];
    assign tgt_boot = in_boot(ACC_ADDR_I);
    assign pc_boot = in_boot(FETCH_PC_I);
    assign boot_page_ok = (page_of(`BFP_BOOT_LAST) - page_of(`BFP_BOOT_FIRST)) ==
        7'(`BFP_BOOT_PAGES - 4'h1);
    assign is_store = ACC_VALID_I && (ACC_KIND_I == BFP_ACC_STORE);
    assign is_load = ACC_VALID_I && (ACC_KIND_I == BFP_ACC_LOAD);
    assign is_lockset = ACC_VALID_I && (ACC_KIND_I == BFP_ACC_LOCKSET) && pc_boot;

    // Permission of the current access; a load from the same part is free.
    always_comb begin
        allow = 1'b0;
        if (is_store) begin
            // Stores only from boot code, then the target's write lock.
            if (!pc_boot) begin
                allow = 1'b0;
            end else if (tgt_boot) begin
                allow = boot_write_lock_bit;
            end else begin
                allow = app_write_lock_bit;
            end
        end else if (is_load) begin
            if (tgt_boot && !pc_boot) begin
                allow = boot_read_lock_bit;
            end else if (!tgt_boot && pc_boot) begin
                allow = app_read_lock_bit;
            end else begin
                allow = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Flash strobes and answer
    // ------------------------------------------------------------------
    // A refused access never strobes the array, so flash stays unchanged.
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            FLASH_WR_O <= 1'b0;
            FLASH_RD_O <= 1'b0;
            FLASH_ADDR_O <= '0;
        end else begin
            FLASH_WR_O <= is_store && allow && boot_page_ok;
            FLASH_RD_O <= is_load && allow;
            FLASH_ADDR_O <= ACC_ADDR_I;
        end
    end

    // Read data are valid one cycle after the read strobe.
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            rd_pend <= 1'b0;
        end else begin
            rd_pend <= FLASH_RD_O;
        end
    end

    // Answer: stores, lock sets and refused loads finish next cycle, allowed loads after data.
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            ACC_DONE_O <= 1'b0;
            ACC_REFUSED_O <= 1'b0;
            ACC_RDATA_O <= '0;
        end else begin
            ACC_DONE_O <= rd_pend || (ACC_VALID_I && !(is_load && allow));
            ACC_REFUSED_O <= ACC_VALID_I && !allow && !is_lockset &&
                !(is_load && allow);
            if (rd_pend) begin
                ACC_RDATA_O <= FLASH_RDATA_I;
            end else if (ACC_VALID_I) begin
                ACC_RDATA_O <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Reset vector
    // ------------------------------------------------------------------
    // Fuse zero (programmed) sends reset into the boot part.
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            RESET_VECTOR_O <= `BFP_RESET_APP;
        end else begin
            RESET_VECTOR_O <= fuse ? `BFP_RESET_APP : `BFP_RESET_BOOT;
        end
    end

    // ------------------------------------------------------------------
    // APB slave (programming port)
    // ------------------------------------------------------------------
    // Fuses are reachable only here, never from the core port.
    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign apb_rd = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign prog_erase = apb_wr && (PADDR_I == `BFP_OFS_PROG) && PWDATA_I[`BFP_PROG_ERASE];
    assign prog_fuse_wr = apb_wr && (PADDR_I == `BFP_OFS_PROG) &&
        PWDATA_I[`BFP_PROG_FUSE_WR];
    assign prog_gl1 = apb_wr && (PADDR_I == `BFP_OFS_PROG) && PWDATA_I[`BFP_PROG_GL1];

    // Zero-wait slave; addresses above 00C read zero with an error.
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= '0;
        end else begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            PSLVERR_O <= PSEL_I && !PENABLE_I && (PADDR_I > `BFP_OFS_STAT);
            if (apb_rd) begin
                unique case (PADDR_I)
                    `BFP_OFS_LOCK: PRDATA_O <= {26'h0, lock, 2'h3};
                    `BFP_OFS_FUSE: PRDATA_O <= {30'h0, gl1, fuse};
                    `BFP_OFS_STAT: PRDATA_O <= {28'h0, pc_boot, tgt_boot, 2'h0};
                    default: PRDATA_O <= '0;
                endcase
            end
        end
    end

    // Lock set from the core or the APB lock register, data bits 5..2.
    logic lock_wr;
    logic [3:0] lock_clr;
    assign lock_wr = is_lockset || (apb_wr && (PADDR_I == `BFP_OFS_LOCK));
    assign lock_clr = is_lockset ? ~ACC_DATA_I[`BFP_LOCK_MSB:`BFP_LOCK_LSB] :
        ~PWDATA_I[`BFP_LOCK_MSB:`BFP_LOCK_LSB];

    bfp_lock_store u_store (
        .clk_i(CLK_SYS_I),
        .rst_i(RESET_I),
        .erase_i(prog_erase),
        .lock_wr_i(lock_wr),
        .lock_clr_i(lock_clr),
        .fuse_wr_i(prog_fuse_wr),
        .fuse_val_i(PWDATA_I[`BFP_PROG_FUSE_VAL]),
        .gl1_wr_i(prog_gl1),
        .lock_o(lock),
        .fuse_o(fuse),
        .gl1_o(gl1)
    );
endmodule

// ===== hw/bfp_defines.svh
`ifndef BFP_DEFINES_SVH
`define BFP_DEFINES_SVH

// ----------------------------------------------------------------------
// Flash partition
// ----------------------------------------------------------------------
`define BFP_APP_LAST 13'h1dff
`define BFP_BOOT_FIRST 13'h1e00
`define BFP_BOOT_LAST 13'h1fff
`define BFP_PAGE_BYTES 8'h80
`define BFP_PAGE_WORDS 7'h40
`define BFP_BOOT_PAGES 4'h8
`define BFP_RESET_APP 13'h0000
`define BFP_RESET_BOOT 13'h1e00

// ----------------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------------
`define BFP_OFS_LOCK 12'h000
`define BFP_OFS_FUSE 12'h004
`define BFP_OFS_PROG 12'h008
`define BFP_OFS_STAT 12'h00c
`define BFP_LOCK_LSB 2
`define BFP_LOCK_MSB 5
`define BFP_PROG_ERASE 0
`define BFP_PROG_FUSE_WR 1
`define BFP_PROG_FUSE_VAL 2
`define BFP_PROG_GL1 3
`define BFP_LOCK_RESET 4'hf
`define BFP_FUSE_RESET 1'h1

`endif

// ===== hw/bfp_pkg.sv
package bfp_pkg;
    // Kind of flash access presented by the core.
    typedef enum logic [1:0] {
        BFP_ACC_NONE,
        BFP_ACC_STORE,
        BFP_ACC_LOAD,
        BFP_ACC_LOCKSET
    } bfp_acc_e;
    typedef logic [12:0] bfp_waddr_t;
endpackage

// ===== hw/bfp_lock_store.sv
`include "bfp_defines.svh"

// ----------------------------------------------------------------------
// Non-volatile lock and fuse cell store
// ----------------------------------------------------------------------
module bfp_lock_store (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic erase_i,
    input wire logic lock_wr_i,
    input wire logic [3:0] lock_clr_i,
    input wire logic fuse_wr_i,
    input wire logic fuse_val_i,
    input wire logic gl1_wr_i,
    output logic [3:0] lock_o,
    output logic fuse_o,
    output logic gl1_o
);
    // Lock cells: only erase or reset returns them to one; writes only program.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_o <= `BFP_LOCK_RESET;
        end else if (erase_i) begin
            lock_o <= `BFP_LOCK_RESET;
        end else if (lock_wr_i) begin
            lock_o <= lock_o & ~lock_clr_i;
        end
    end

    // Boot reset fuse: frozen while the general lock bit is programmed.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fuse_o <= `BFP_FUSE_RESET;
        end else if (fuse_wr_i && gl1_o) begin
            fuse_o <= fuse_val_i;
        end
    end

    // General lock bit one, programmed to zero, cleared by erase.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gl1_o <= 1'b1;
        end else if (erase_i) begin
            gl1_o <= 1'b1;
        end else if (gl1_wr_i) begin
            gl1_o <= 1'b0;
        end
    end
endmodule

// ===== verification/bfp_top_asserts.sv
// ----------------------------------------
// Port-level protection checker
// ----------------------------------------
module bfp_top_asserts (
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    input wire logic ACC_VALID_I,
    input wire bfp_pkg::bfp_acc_e ACC_KIND_I,
    input wire bfp_pkg::bfp_waddr_t ACC_ADDR_I,
    input wire bfp_pkg::bfp_waddr_t FETCH_PC_I,
    input wire logic FLASH_WR_O,
    input wire logic FLASH_RD_O,
    input wire bfp_pkg::bfp_waddr_t FLASH_ADDR_O,
    input wire logic ACC_DONE_O,
    input wire logic ACC_REFUSED_O,
    input wire logic [15:0] ACC_RDATA_O,
    input wire bfp_pkg::bfp_waddr_t RESET_VECTOR_O,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O
);
    timeunit 1ns;
    timeprecision 1ns;
    import bfp_pkg::*;
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RESET_I);

    // Core side: a write strobe must always trace back to a request fetched from boot.
    property p_store_pc;
        ACC_VALID_I && ACC_KIND_I == BFP_ACC_STORE && FETCH_PC_I < 13'h1e00
            |=> ACC_REFUSED_O && !FLASH_WR_O;
    endproperty
    a_store_pc: assert property (p_store_pc)
        else $error("store fetched from application code went through");
    property p_wr_cause;
        FLASH_WR_O |-> $past(ACC_VALID_I) && $past(FETCH_PC_I) >= 13'h1e00 && ACC_DONE_O;
    endproperty
    a_wr_cause: assert property (p_wr_cause)
        else $error("array write without a boot-part store");
    property p_rd_same;
        ACC_VALID_I && ACC_KIND_I == BFP_ACC_LOAD
            && ((ACC_ADDR_I >= 13'h1e00) == (FETCH_PC_I >= 13'h1e00))
            |=> FLASH_RD_O && FLASH_ADDR_O == $past(ACC_ADDR_I);
    endproperty
    a_rd_same: assert property (p_rd_same)
        else $error("same-part load did not reach the array");
    property p_rd_done;
        FLASH_RD_O |=> !ACC_DONE_O ##1 ACC_DONE_O && !ACC_REFUSED_O;
    endproperty
    a_rd_done: assert property (p_rd_done)
        else $error("load completion late or refused");
    property p_lockset;
        ACC_VALID_I && ACC_KIND_I == BFP_ACC_LOCKSET && FETCH_PC_I >= 13'h1e00
            |=> ACC_DONE_O && !ACC_REFUSED_O && !FLASH_WR_O && !FLASH_RD_O;
    endproperty
    a_lockset: assert property (p_lockset)
        else $error("lock-set access touched the array");
    // A lock set from application code must be turned away, never executed.
    property p_lockset_app;
        ACC_VALID_I && ACC_KIND_I == BFP_ACC_LOCKSET && FETCH_PC_I < 13'h1e00
            |=> ACC_DONE_O && ACC_REFUSED_O && !FLASH_WR_O;
    endproperty
    a_lockset_app: assert property (p_lockset_app)
        else $error("lock set from application code was not refused");
    property p_refused;
        ACC_REFUSED_O |-> ACC_DONE_O && ACC_RDATA_O == 16'h0 && !FLASH_WR_O && !FLASH_RD_O;
    endproperty
    a_refused: assert property (p_refused)
        else $error("refused access leaked data or a strobe");
    property p_vector;
        RESET_VECTOR_O == 13'h0000 || RESET_VECTOR_O == 13'h1e00;
    endproperty
    a_vector: assert property (p_vector)
        else $error("reset vector outside the two legal values");
    property p_slverr;
        PSEL_I && !PENABLE_I && PADDR_I > 12'h00c |=> PREADY_O && PSLVERR_O;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("unmapped register access not flagged");

    c_refused: cover property (ACC_REFUSED_O);
    c_load: cover property (FLASH_RD_O);
    c_slverr: cover property (PSLVERR_O);
endmodule

bind bfp_top bfp_top_asserts u_chk (.*);

// ===== verification/bfp_flash_model.sv
// ----------------------------------------
// Flash array stand-in
// ----------------------------------------
module bfp_flash_model (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire bfp_pkg::bfp_waddr_t addr_i,
    output logic [15:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import bfp_pkg::*;
    initial rdata_o = 16'h0;
    // Data stands only the cycle after a strobe; otherwise it toggles so a
    // sample taken on the wrong cycle cannot match by luck.
    always @(posedge clk_i) begin
        rdata_o <= rd_i ? {3'h5, addr_i} : ~rdata_o;
    end
endmodule

// ===== verification/boot_flash_protection_tb_top.sv
module boot_flash_protection_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import bfp_pkg::*;
    logic CLK_SYS_I = 1'b0;
    logic RESET_I = 1'b1;
    logic ACC_VALID_I = 1'b0;
    bfp_acc_e ACC_KIND_I = BFP_ACC_NONE;
    bfp_waddr_t ACC_ADDR_I = '0;
    bfp_waddr_t FETCH_PC_I = '0;
    logic [7:0] ACC_DATA_I = 8'h0;
    logic FLASH_WR_O, FLASH_RD_O, ACC_DONE_O, ACC_REFUSED_O, PREADY_O, PSLVERR_O;
    bfp_waddr_t FLASH_ADDR_O, RESET_VECTOR_O;
    logic [15:0] FLASH_RDATA_I, ACC_RDATA_O;
    logic PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
    logic [11:0] PADDR_I = '0;
    logic [31:0] PWDATA_I = '0, PRDATA_O, lfsr = 32'h1f71;
    logic [16:0] q [$];
    logic [16:0] e;
    logic [3:0] lk = 4'hf;
    logic [7:0] sets [7] = '{8'hff, 8'hfb, 8'hf7, 8'hf3, 8'hef, 8'hdf, 8'hcf};
    int err_total = 0;
    int n_compared = 0;

    always #20 CLK_SYS_I = ~CLK_SYS_I;
    bfp_top dut (.*);
    bfp_flash_model u_flash (.clk_i(CLK_SYS_I), .rd_i(FLASH_RD_O), .addr_i(FLASH_ADDR_O),
        .rdata_o(FLASH_RDATA_I));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // One core access; the expected answer is queued before the request goes out.
    task automatic acc(input bfp_acc_e k, input bfp_waddr_t a, input bfp_waddr_t p,
            input logic [7:0] d);
        logic tb, pb, rf;
        tb = a >= 13'h1e00;
        pb = p >= 13'h1e00;
        // A lock set fetched from application code is refused like any store.
        rf = k == BFP_ACC_STORE ? (!pb || (tb ? !lk[2] : !lk[0]))
            : k == BFP_ACC_LOCKSET ? !pb
            : (k == BFP_ACC_LOAD && tb != pb && (tb ? !lk[3] : !lk[1]));
        q.push_back({rf, (k == BFP_ACC_LOAD && !rf) ? {3'h5, a} : 16'h0});
        if (k == BFP_ACC_LOCKSET && pb) lk = lk & d[5:2];
        ACC_VALID_I <= 1'b1;
        ACC_KIND_I <= k;
        ACC_ADDR_I <= a;
        FETCH_PC_I <= p;
        ACC_DATA_I <= d;
        @(posedge CLK_SYS_I);
        ACC_VALID_I <= 1'b0;
        repeat (6) if (q.size() != 0) @(posedge CLK_SYS_I);
        chk("access done", 32'h0, 32'(q.size()));
        q.delete();
    endtask

    // Completions are matched in order against the queued expectations.
    always @(posedge CLK_SYS_I) begin
        if (ACC_DONE_O === 1'b1) begin
            e = q.size() != 0 ? q.pop_front() : 17'h1ffff;
            chk("access answer", {15'h0, e}, {15'h0, ACC_REFUSED_O, ACC_RDATA_O});
        end
    end

    // APB master: setup, then access held until ready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
            input logic [31:0] exp);
        PSEL_I <= 1'b1;
        PWRITE_I <= w;
        PADDR_I <= a;
        PWDATA_I <= wd;
        @(posedge CLK_SYS_I);
        PENABLE_I <= 1'b1;
        @(posedge CLK_SYS_I);
        // No wait count is assumed here; only the watchdog ends a stuck access.
        while (PREADY_O !== 1'b1) @(posedge CLK_SYS_I);
        chk("apb error", {31'h0, a > 12'h00c}, {31'h0, PSLVERR_O});
        if (!w) chk("apb read", exp, PRDATA_O);
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
        @(posedge CLK_SYS_I);
    endtask

    initial begin
        repeat (20000) @(posedge CLK_SYS_I);
        err_total++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge CLK_SYS_I);
        RESET_I <= 1'b0;
        @(posedge CLK_SYS_I);
        chk("vector", 32'h0, {19'h0, RESET_VECTOR_O});
        apb(0, 12'h000, 0, 32'h3f);
        apb(0, 12'h010, 0, 32'h0);
        // Every encoding of each two-bit lock, the other left at 11, against all store/load, target and fetch-part mixes.
        foreach (sets[s]) begin
            apb(1, 12'h008, 32'h1, 0);
            lk = 4'hf;
            acc(BFP_ACC_LOCKSET, 13'h0, 13'h0100, 8'h00);
            acc(BFP_ACC_LOCKSET, 13'h0, 13'h1f00, sets[s]);
            apb(0, 12'h000, 0, {26'h0, lk, 2'b11});
            for (int c = 0; c < 8; c++) begin
                lfsr = nxt(lfsr);
                acc(c[0] ? BFP_ACC_LOAD : BFP_ACC_STORE,
                    c[1] ? 13'h1e00 | lfsr[8:0] : lfsr[12:0] % 13'h1e00,
                    c[2] ? 13'h1e00 | lfsr[24:16] : lfsr[28:16] % 13'h1e00, 8'h0);
            end
        end
        acc(BFP_ACC_STORE, 13'h1dff, 13'h1e00, 8'h0);
        acc(BFP_ACC_LOAD, 13'h1e00, 13'h1dff, 8'h0);
        apb(0, 12'h004, 0, 32'h3);
        apb(1, 12'h008, 32'h2, 0);
        apb(0, 12'h004, 0, 32'h2);
        chk("vector", 32'h1e00, {19'h0, RESET_VECTOR_O});
        apb(1, 12'h008, 32'h8, 0);
        apb(1, 12'h008, 32'h6, 0);
        apb(0, 12'h004, 0, 32'h0);
        apb(1, 12'h008, 32'h1, 0);
        apb(1, 12'h008, 32'h6, 0);
        apb(0, 12'h004, 0, 32'h3);
        apb(0, 12'h000, 0, 32'h3f);
        apb(1, 12'h000, 32'h3b, 0);
        apb(0, 12'h000, 0, 32'h3b);
        lk = 4'he;
        acc(BFP_ACC_STORE, 13'h0100, 13'h1e00, 8'h0);
        apb(0, 12'h00c, 0, 32'h8);
        chk("vector", 32'h0, {19'h0, RESET_VECTOR_O});
        conclude();
    end
endmodule
